// ### logic/bus_monitor_store.sv
// Bus monitor: filters 1553 messages and stores monitor blocks in memory.
`timescale 1ns/1ps
// How it works
// - Monitor role chosen by pins or field.
// - Store a monitor information word per message.
// - Combined role never captures own address.
// - Write command, status, pointer into eight-word block.
// - Capture only addresses enabled in filters.
// - On error drop data, flag information word.
// - In combined role, own-terminal message halts monitoring at once.
// - Terminal function owns whole transfer involving us.
// - External memory spans 64k sixteen-bit words.
// - First block stored at block pointer.
// - Counter decrements; at zero reload and restart.
// - Data words start at data pointer.
// - Each block holds its data pointer.
// - Keep 32-word aligned log ring.
// - Block format matches controller command blocks.
// - Setup in registers, captures in memory.
// - Fixed order of the eight block words.
// - Information bit 9 marks bus A.
// - Time tag caught at command, written at end.
// - Transmitter status word 4, receiver word 5.
module bus_monitor_store import monitor_pkg::*; (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [1:0] role_select_pins,
	input wire logic cpuSel,
	input wire logic cpuWrite,
	input wire logic [5:0] cpuAddr,
	input wire logic [15:0] cpuWrData,
	output logic [15:0] cpuRdData,
	input wire logic wordStrobe,
	input wire logic [15:0] wordValue,
	input wire logic wordIsSync,
	input wire logic wordOnBusA,
	input wire logic wordParityError,
	input wire logic wordManchesterError,
	input wire logic busGap,
	input wire logic [4:0] ownAddress,
	input wire logic rtActive,
	input wire logic memAck,
	output logic [15:0] memAddr,
	output logic [15:0] memWrData,
	output logic memWrite
);
	logic [1:0] pinMeta;
	logic [1:0] pinSync;
	logic [15:0] coreControl, irqMask, irqPending, selfTest, extraFeature;
	logic [1:0] role_select_field;
	logic [15:0] lastCommand, timestamp, blockPtr, dataPtr, blockInit;
	logic [15:0] filterLow, filterHigh, blockCount, blockAddr, dataAddr;
	logic [15:0] logPtr, curBlock, cmd1, cmd2, stat1, stat2, msgTime;
	logic [15:0] msgDataPtr;
	logic [5:0] tickCount, needData, dataSeen;
	logic [1:0] needStat, statSeen;
	logic [2:0] storeIdx;
	logic msgBusA, rtrt, hit, mcwd, bcast, cmd1Tx;
	logic toErr, ovrErr, parErr, manErr, msgErr, complete;
	logic [1:0] role;
	logic monitorOn, combined, hostWrite;
	logic decHit, decOwn, decTx, decBcast, decModeNoData;
	logic [5:0] decCount;
	logic takeCmd1, takeCmd2, haltNow, finish, memBusy;
	logic wrReq;
	logic [15:0] wrAddr, wrData, infoWord;
	mon_state_type state;

	cmd_word_decode decoder (
		.cmdWord(wordValue),
		.filterLow(filterLow),
		.filterHigh(filterHigh),
		.ownAddress(ownAddress),
		.filterHit(decHit),
		.ownHit(decOwn),
		.isTransmit(decTx),
		.isBroadcast(decBcast),
		.isModeNoData(decModeNoData),
		.dataCount(decCount)
	);

	mem_write_port writer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.wrReq(wrReq),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.memAck(memAck),
		.busy(memBusy),
		.memAddr(memAddr),
		.memWrData(memWrData),
		.memWrite(memWrite)
	);

	// Role pins come from outside and are synchronised first.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pinMeta <= 2'h0;
			pinSync <= 2'h0;
		end else begin
			pinMeta <= role_select_pins;
			pinSync <= pinMeta;
		end
	end

	always_comb begin
		role = (role_select_field != ROLE_OFF) ? role_select_field : pinSync;
		monitorOn = (role == ROLE_MONITOR) || (role == ROLE_RT_MONITOR);
		combined = (role == ROLE_RT_MONITOR);
		hostWrite = cpuSel && cpuWrite;
		msgErr = toErr || ovrErr || parErr || manErr;
		complete = (statSeen == needStat) && (dataSeen == needData);
		takeCmd1 = (state == ST_IDLE) && monitorOn && wordStrobe && wordIsSync;
		// A sync word straight after a receive command is the transmit command.
		takeCmd2 = (state == ST_TAKE) && wordStrobe && wordIsSync && !rtrt &&
			!cmd1Tx && (dataSeen == 6'h00) && (statSeen == 2'h0) && decTx;
		haltNow = combined && (rtActive || ((takeCmd1 || takeCmd2) && decOwn)) &&
			((state == ST_IDLE) || (state == ST_TAKE));
		finish = (state == ST_TAKE) && !wordStrobe && (complete || busGap);
		infoWord = {MIW_OPCODE, MIW_RETRY, msgBusA, rtrt, msgErr, mcwd, bcast,
			1'b0, toErr, ovrErr, parErr, manErr};
	end

	// Write requests: data during a message, then block words, then log.
	always_comb begin
		wrReq = 1'b0;
		wrAddr = RESET_WORD;
		wrData = RESET_WORD;
		if (state == ST_TAKE && wordStrobe && !wordIsSync && hit && !msgErr &&
			!wordParityError && !wordManchesterError && dataSeen < needData) begin
			wrReq = !memBusy;
			wrAddr = msgDataPtr + {10'h000, dataSeen};
			wrData = wordValue;
		end else if (state == ST_STORE) begin
			wrReq = !memBusy;
			wrAddr = curBlock + {13'h0000, storeIdx};
			unique case (storeIdx)
				WORD_INFO: wrData = infoWord;
				WORD_CMD1: wrData = cmd1;
				WORD_CMD2: wrData = cmd2;
				WORD_DPTR: wrData = msgDataPtr;
				WORD_STAT1: wrData = stat1;
				WORD_STAT2: wrData = stat2;
				WORD_TIME: wrData = msgTime;
				WORD_LAST: wrData = RESET_WORD;
			endcase
		end else if (state == ST_LOG) begin
			wrReq = !memBusy;
			wrAddr = logPtr;
			wrData = curBlock;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			storeIdx <= 3'h0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (haltNow) begin
						state <= ST_HALT;
					end else if (takeCmd1) begin
						state <= ST_TAKE;
					end
				end
				ST_TAKE: begin
					if (haltNow) begin
						state <= ST_HALT;
					end else if (finish) begin
						state <= hit ? ST_STORE : ST_IDLE;
					end
				end
				ST_STORE: begin
					if (!memBusy) begin
						storeIdx <= storeIdx + 3'h1;
						if (storeIdx == WORD_LAST) begin
							state <= ST_LOG;
						end
					end
				end
				ST_LOG: begin
					if (!memBusy) begin
						state <= ST_IDLE;
					end
				end
				ST_HALT: begin
					if (!rtActive && busGap) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Message capture: command, status and error bookkeeping.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cmd1 <= RESET_WORD;
			cmd2 <= RESET_WORD;
			stat1 <= RESET_WORD;
			stat2 <= RESET_WORD;
			msgTime <= RESET_WORD;
			msgDataPtr <= RESET_WORD;
			needData <= 6'h00;
			needStat <= 2'h0;
			dataSeen <= 6'h00;
			statSeen <= 2'h0;
			{msgBusA, rtrt, hit, mcwd, bcast, cmd1Tx} <= 6'h00;
			{toErr, ovrErr, parErr, manErr} <= 4'h0;
		end else if (takeCmd1 && !haltNow) begin
			cmd1 <= wordValue;
			cmd2 <= RESET_WORD;
			stat1 <= RESET_WORD;
			stat2 <= RESET_WORD;
			msgTime <= timestamp;
			msgDataPtr <= dataAddr;
			needData <= decCount;
			needStat <= decBcast ? 2'h0 : 2'h1;
			dataSeen <= 6'h00;
			statSeen <= 2'h0;
			msgBusA <= wordOnBusA;
			rtrt <= 1'b0;
			hit <= decHit && !(combined && decOwn);
			mcwd <= decModeNoData;
			bcast <= decBcast;
			cmd1Tx <= decTx;
			toErr <= 1'b0;
			ovrErr <= 1'b0;
			parErr <= wordParityError;
			manErr <= wordManchesterError;
		end else if (takeCmd2 && !haltNow) begin
			cmd2 <= wordValue;
			rtrt <= 1'b1;
			hit <= hit || decHit;
			needData <= decCount;
			needStat <= bcast ? 2'h1 : 2'h2;
			parErr <= parErr || wordParityError;
			manErr <= manErr || wordManchesterError;
		end else if (state == ST_TAKE && wordStrobe) begin
			parErr <= parErr || wordParityError;
			manErr <= manErr || wordManchesterError;
			if (wordIsSync) begin
				if (statSeen >= needStat) begin
					ovrErr <= 1'b1;
				end else if (statSeen == 2'h0) begin
					stat1 <= wordValue;
					statSeen <= 2'h1;
				end else begin
					stat2 <= wordValue;
					statSeen <= 2'h2;
				end
			end else if (dataSeen >= needData) begin
				ovrErr <= 1'b1;
			end else begin
				dataSeen <= dataSeen + 6'h01;
			end
		end else if (finish && !complete) begin
			toErr <= 1'b1;
		end
	end

	// Block ring, data area and log pointer; host writes take priority.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			blockAddr <= RESET_WORD;
			dataAddr <= RESET_WORD;
			blockCount <= RESET_WORD;
			blockInit <= RESET_WORD;
			curBlock <= RESET_WORD;
			logPtr <= RESET_WORD;
		end else if (hostWrite && cpuAddr == REG_BLKPTR) begin
			blockAddr <= cpuWrData;
		end else if (hostWrite && cpuAddr == REG_DATAPTR) begin
			dataAddr <= cpuWrData;
		end else if (hostWrite && cpuAddr == REG_BLKCNT) begin
			blockCount <= cpuWrData;
			blockInit <= cpuWrData;
		end else if (hostWrite && cpuAddr == REG_LOGPTR) begin
			logPtr <= cpuWrData;
		end else if (finish && hit) begin
			if (blockCount == RESET_WORD) begin
				curBlock <= blockPtr;
				blockAddr <= blockPtr + BLOCK_STRIDE;
				blockCount <= blockInit - 16'h0001;
			end else begin
				curBlock <= blockAddr;
				blockAddr <= blockAddr + BLOCK_STRIDE;
				blockCount <= blockCount - 16'h0001;
			end
			if (!msgErr && complete) begin
				dataAddr <= dataAddr + {10'h000, dataSeen};
			end
		end else if (state == ST_LOG && !memBusy) begin
			logPtr <= {logPtr[15:LOG_BITS], logPtr[LOG_BITS-1:0] + 5'h01};
		end
	end

	// Microsecond time tag counter.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tickCount <= 6'h00;
			timestamp <= RESET_WORD;
		end else if (hostWrite && cpuAddr == REG_TIMESTAMP) begin
			tickCount <= 6'h00;
			timestamp <= cpuWrData;
		end else if (tickCount == 6'(TICK_CYCLES - 1)) begin
			tickCount <= 6'h00;
			timestamp <= timestamp + 16'h0001;
		end else begin
			tickCount <= tickCount + 6'h01;
		end
	end

	// Host registers held on chip, plus the last command word taken from the bus.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			coreControl <= RESET_WORD;
			role_select_field <= ROLE_OFF;
			irqMask <= RESET_WORD;
			irqPending <= RESET_WORD;
			selfTest <= RESET_WORD;
			blockPtr <= RESET_WORD;
			dataPtr <= RESET_WORD;
			filterLow <= RESET_WORD;
			filterHigh <= RESET_WORD;
			extraFeature <= RESET_WORD;
			lastCommand <= RESET_WORD;
		end else begin
			if (takeCmd1) begin
				lastCommand <= wordValue;
			end
			if (hostWrite) begin
				unique case (cpuAddr)
					REG_CONTROL: coreControl <= cpuWrData;
					REG_OPSTATE: role_select_field <= cpuWrData[ROLE_MSB:ROLE_LSB];
					REG_IRQMASK: irqMask <= cpuWrData;
					REG_IRQPEND: irqPending <= cpuWrData;
					REG_SELFTEST: selfTest <= cpuWrData;
					REG_BLKPTR: blockPtr <= cpuWrData;
					REG_DATAPTR: dataPtr <= cpuWrData;
					REG_FILTLOW: filterLow <= cpuWrData;
					REG_FILTHIGH: filterHigh <= cpuWrData;
					REG_EXTRA: extraFeature <= cpuWrData & {14'h0000, EXTRA_MASK};
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cpuRdData <= RESET_WORD;
		end else if (cpuSel && !cpuWrite) begin
			unique case (cpuAddr)
				REG_CONTROL: cpuRdData <= coreControl;
				REG_OPSTATE: cpuRdData <= {6'h00, role_select_field, 7'h00,
					state != ST_IDLE};
				REG_LASTCMD: cpuRdData <= lastCommand;
				REG_IRQMASK: cpuRdData <= irqMask;
				REG_IRQPEND: cpuRdData <= irqPending;
				REG_LOGPTR: cpuRdData <= logPtr;
				REG_SELFTEST: cpuRdData <= selfTest;
				REG_TIMESTAMP: cpuRdData <= timestamp;
				REG_BLKPTR: cpuRdData <= blockPtr;
				REG_DATAPTR: cpuRdData <= dataPtr;
				REG_BLKCNT: cpuRdData <= blockCount;
				REG_FILTLOW: cpuRdData <= filterLow;
				REG_FILTHIGH: cpuRdData <= filterHigh;
				REG_EXTRA: cpuRdData <= extraFeature;
				default: cpuRdData <= RESET_WORD;
			endcase
		end
	end

	a_role_select: assert property (@(posedge core_clk) disable iff (sys_rst)
		(role_select_field == ROLE_OFF && pinSync == ROLE_MONITOR) |-> monitorOn)
		else $error("monitor role from pins not taken");
	a_own_halt: assert property (@(posedge core_clk) disable iff (sys_rst)
		(combined && state == ST_TAKE && wordStrobe && wordIsSync && decOwn &&
		takeCmd2) |=> state == ST_HALT)
		else $error("own terminal message did not halt monitor");
	a_own_no_hit: assert property (@(posedge core_clk) disable iff (sys_rst)
		(takeCmd1 && combined && decOwn) |=> state == ST_HALT)
		else $error("own address was captured");
	a_block_stride: assert property (@(posedge core_clk) disable iff (sys_rst)
		(finish && hit && blockCount != RESET_WORD && !hostWrite) |=>
		blockAddr == $past(blockAddr) + BLOCK_STRIDE)
		else $error("block address did not advance by eight");
	a_wrap_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
		(finish && hit && blockCount == RESET_WORD && !hostWrite) |=>
		curBlock == blockPtr && blockCount == blockInit - 16'h0001)
		else $error("block ring did not reload at zero");
	a_err_no_data: assert property (@(posedge core_clk) disable iff (sys_rst)
		(state == ST_TAKE && msgErr) |-> !(wrReq && !wordIsSync && wordStrobe))
		else $error("data stored after an error");
	a_time_caught: assert property (@(posedge core_clk) disable iff (sys_rst)
		(takeCmd1 && !haltNow) |=> msgTime == $past(timestamp))
		else $error("time tag not caught at command");
	a_log_aligned: assert property (@(posedge core_clk) disable iff (sys_rst)
		(state == ST_LOG && !memBusy && !hostWrite) |=>
		logPtr[15:LOG_BITS] == $past(logPtr[15:LOG_BITS]))
		else $error("log pointer left its aligned ring");
	a_store_len: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(state == ST_STORE) |-> ##[8:200] state == ST_LOG)
		else $error("monitor block store did not finish");
	c_block_stored: cover property (@(posedge core_clk) state == ST_LOG);
	c_rt_to_rt: cover property (@(posedge core_clk) takeCmd2 && !haltNow);
	c_halted: cover property (@(posedge core_clk) state == ST_HALT);
	c_timeout: cover property (@(posedge core_clk) finish && !complete && hit);
endmodule : bus_monitor_store

// ### logic/monitor_pkg.sv
// Constants and types shared by the bus monitor message store.
package monitor_pkg;
	localparam logic [5:0] REG_CONTROL = 6'h00;
	localparam logic [5:0] REG_OPSTATE = 6'h01;
	localparam logic [5:0] REG_LASTCMD = 6'h02;
	localparam logic [5:0] REG_IRQMASK = 6'h03;
	localparam logic [5:0] REG_IRQPEND = 6'h04;
	localparam logic [5:0] REG_LOGPTR = 6'h05;
	localparam logic [5:0] REG_SELFTEST = 6'h06;
	localparam logic [5:0] REG_TIMESTAMP = 6'h07;
	localparam logic [5:0] REG_BLKPTR = 6'h0b;
	localparam logic [5:0] REG_DATAPTR = 6'h0c;
	localparam logic [5:0] REG_BLKCNT = 6'h0d;
	localparam logic [5:0] REG_FILTLOW = 6'h0e;
	localparam logic [5:0] REG_FILTHIGH = 6'h0f;
	localparam logic [5:0] REG_EXTRA = 6'h20;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam int ROLE_LSB = 8;
	localparam int ROLE_MSB = 9;
	localparam int OPSTATE_BUSY_BIT = 0;
	localparam logic [1:0] ROLE_OFF = 2'h0;
	localparam logic [1:0] ROLE_MONITOR = 2'h2;
	localparam logic [1:0] ROLE_RT_MONITOR = 2'h3;
	localparam logic [1:0] EXTRA_MASK = 2'h3;
	localparam int CMD_ADDR_MSB = 15;
	localparam int CMD_ADDR_LSB = 11;
	localparam int CMD_TX_BIT = 10;
	localparam int CMD_SA_MSB = 9;
	localparam int CMD_SA_LSB = 5;
	localparam int CMD_WC_MSB = 4;
	localparam int MODE_DATA_BIT = 4;
	localparam logic [4:0] BCAST_ADDR = 5'h1f;
	localparam logic [4:0] MODE_SA_LOW = 5'h00;
	localparam logic [4:0] MODE_SA_HIGH = 5'h1f;
	localparam logic [5:0] FULL_WORD_COUNT = 6'h20;
	localparam logic [3:0] MIW_OPCODE = 4'h4;
	localparam logic [1:0] MIW_RETRY = 2'h0;
	localparam logic [15:0] BLOCK_STRIDE = 16'h0008;
	localparam logic [2:0] WORD_INFO = 3'h0;
	localparam logic [2:0] WORD_CMD1 = 3'h1;
	localparam logic [2:0] WORD_CMD2 = 3'h2;
	localparam logic [2:0] WORD_DPTR = 3'h3;
	localparam logic [2:0] WORD_STAT1 = 3'h4;
	localparam logic [2:0] WORD_STAT2 = 3'h5;
	localparam logic [2:0] WORD_TIME = 3'h6;
	localparam logic [2:0] WORD_LAST = 3'h7;
	localparam int LOG_BITS = 5;
	localparam int CLK_NS = 20;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;
	typedef enum {ST_IDLE, ST_TAKE, ST_STORE, ST_LOG, ST_HALT} mon_state_type;
endpackage : monitor_pkg

// ### logic/cmd_word_decode.sv
// Decodes one 1553 command word against the address filters.
`timescale 1ns/1ps
module cmd_word_decode import monitor_pkg::*; (
	input wire logic [15:0] cmdWord,
	input wire logic [15:0] filterLow,
	input wire logic [15:0] filterHigh,
	input wire logic [4:0] ownAddress,
	output logic filterHit,
	output logic ownHit,
	output logic isTransmit,
	output logic isBroadcast,
	output logic isModeNoData,
	output logic [5:0] dataCount
);
	logic [4:0] addr;
	logic [4:0] subAddr;
	logic [4:0] wordCount;
	logic isMode;

	always_comb begin
		addr = cmdWord[CMD_ADDR_MSB:CMD_ADDR_LSB];
		subAddr = cmdWord[CMD_SA_MSB:CMD_SA_LSB];
		wordCount = cmdWord[CMD_WC_MSB:0];
		isMode = (subAddr == MODE_SA_LOW) || (subAddr == MODE_SA_HIGH);
		// Filter low holds addresses 0..15, filter high 16..31.
		filterHit = addr[4] ? filterHigh[addr[3:0]] : filterLow[addr[3:0]];
		ownHit = (addr == ownAddress);
		isTransmit = cmdWord[CMD_TX_BIT];
		isBroadcast = (addr == BCAST_ADDR);
		isModeNoData = isMode && !wordCount[MODE_DATA_BIT];
		if (isMode) begin
			dataCount = {5'h00, wordCount[MODE_DATA_BIT]};
		end else if (wordCount == 5'h00) begin
			dataCount = FULL_WORD_COUNT;
		end else begin
			dataCount = {1'b0, wordCount};
		end
	end
endmodule : cmd_word_decode

// ### logic/mem_write_port.sv
// Holds one external memory write until the memory acknowledges it.
`timescale 1ns/1ps
module mem_write_port (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic wrReq,
	input wire logic [15:0] wrAddr,
	input wire logic [15:0] wrData,
	input wire logic memAck,
	output logic busy,
	output logic [15:0] memAddr,
	output logic [15:0] memWrData,
	output logic memWrite
);
	assign busy = memWrite;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			memWrite <= 1'b0;
			memAddr <= 16'h0000;
			memWrData <= 16'h0000;
		end else if (!memWrite && wrReq) begin
			memWrite <= 1'b1;
			memAddr <= wrAddr;
			memWrData <= wrData;
		end else if (memAck) begin
			memWrite <= 1'b0;
		end
	end
endmodule : mem_write_port

// ### tb/bus_traffic_model.sv
// Bus terminals and backend memory seen from the monitor store.
`timescale 1ns/1ps
module bus_traffic_model (
	input wire logic core_clk,
	input wire logic memWrite,
	output logic memAck,
	output logic wordStrobe,
	output logic [15:0] wordValue,
	output logic wordIsSync,
	output logic wordOnBusA,
	output logic wordParityError,
	output logic wordManchesterError
);
	int seed = 3881;
	int stall = 0;
	initial begin
		memAck = 1'b0;
		wordStrobe = 1'b0;
		wordValue = 16'h0000;
		wordIsSync = 1'b0;
		wordOnBusA = 1'b0;
		{wordManchesterError, wordParityError} = 2'h0;
	end
	// Each write is acknowledged once, after a random stall of 0 to 3 cycles.
	// The write strobe has already dropped when the acknowledge is cleared,
	// so a request raised right after it is a new write and is served.
	always @(negedge core_clk) begin
		if (memAck) begin
			memAck <= 1'b0;
		end else if (memWrite) begin
			if (stall == 0) begin
				memAck <= 1'b1;
				stall <= {$random(seed)} % 4;
			end else begin
				stall <= stall - 1;
			end
		end
	end
	task automatic send(input logic [15:0] v, input logic sync,
		input logic busA, input logic [1:0] errs);
		@(negedge core_clk);
		wordStrobe = 1'b1;
		wordValue = v;
		wordIsSync = sync;
		wordOnBusA = busA;
		{wordManchesterError, wordParityError} = errs;
		@(negedge core_clk);
		wordStrobe = 1'b0;
		wordValue = ~v;
		repeat (8) @(negedge core_clk);
	endtask : send
endmodule : bus_traffic_model

// ### tb/bus_monitor_store_bench.sv
// Self-checking bench for the bus monitor message store.
`timescale 1ns/1ps
module bus_monitor_store_bench import monitor_pkg::*; ;
	typedef struct packed {
		logic [15:0] a;
		logic [15:0] d;
		logic [15:0] m;
	} note_type;
	localparam logic [15:0] BLK_BASE = 16'h1000;
	localparam logic [15:0] DATA_BASE = 16'h2000;
	localparam logic [15:0] LOG_BASE = 16'h041e;
	localparam int INIT_CNT = 2;
	localparam int LIMIT = 20000;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] rolePins = 2'h0;
	logic cpuSel = 1'b0;
	logic cpuWrite = 1'b0;
	logic [5:0] cpuAddr = 6'h00;
	logic [15:0] cpuWrData = 16'h0000;
	logic busGap = 1'b1;
	logic rtActive = 1'b0;
	logic [4:0] ownAddress = 5'h1e;
	logic [15:0] cpuRdData, memAddr, memWrData, wordValue;
	logic memAck, memWrite, wordStrobe, wordIsSync, wordOnBusA;
	logic wordParityError, wordManchesterError;
	note_type memQ[$];
	logic [15:0] rdQ[$];
	logic [15:0] blkAddr = BLK_BASE;
	logic [15:0] dAddr = DATA_BASE;
	logic [15:0] logPtr = LOG_BASE;
	int cnt = INIT_CNT;
	int mismatches = 0;
	int testsRun = 0;
	int cycles = 0;
	int seed = 3881;
	logic onA = 1'b1;
	logic rdPend = 1'b0;
	logic [5:0] regs [14] = '{REG_CONTROL, REG_OPSTATE, REG_LASTCMD,
		REG_IRQMASK, REG_IRQPEND, REG_LOGPTR, REG_SELFTEST, REG_BLKPTR,
		REG_DATAPTR, REG_BLKCNT, REG_FILTLOW, REG_FILTHIGH, REG_EXTRA, 6'h10};

	always #10 core_clk = ~core_clk;

	bus_monitor_store i_bus_monitor_store (
		.core_clk(core_clk), .sys_rst(sys_rst), .role_select_pins(rolePins),
		.cpuSel(cpuSel), .cpuWrite(cpuWrite), .cpuAddr(cpuAddr),
		.cpuWrData(cpuWrData), .cpuRdData(cpuRdData),
		.wordStrobe(wordStrobe), .wordValue(wordValue),
		.wordIsSync(wordIsSync), .wordOnBusA(wordOnBusA),
		.wordParityError(wordParityError),
		.wordManchesterError(wordManchesterError), .busGap(busGap),
		.ownAddress(ownAddress), .rtActive(rtActive), .memAck(memAck),
		.memAddr(memAddr), .memWrData(memWrData), .memWrite(memWrite)
	);
	bus_traffic_model i_bus_traffic_model (
		.core_clk(core_clk), .memWrite(memWrite), .memAck(memAck),
		.wordStrobe(wordStrobe), .wordValue(wordValue),
		.wordIsSync(wordIsSync), .wordOnBusA(wordOnBusA),
		.wordParityError(wordParityError),
		.wordManchesterError(wordManchesterError)
	);

	task give_verdict();
		$display("compares %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict
	task automatic check_reg(input logic [15:0] got);
		logic [15:0] e;
		e = rdQ.pop_front();
		testsRun++;
		if (got !== e) begin
			mismatches++;
			$display("unexpected read at %0t: %h vs %h", $time, got, e);
		end
	endtask : check_reg
	task automatic check_mem(input logic [15:0] ga, input logic [15:0] gd);
		note_type n;
		n = '0;
		testsRun++;
		if (memQ.size() != 0) n = memQ.pop_front();
		else n.a = ~ga;
		if (ga !== n.a || (gd & n.m) !== (n.d & n.m)) begin
			mismatches++;
			$display("unexpected write at %0t: %h %h vs %h %h", $time, ga, gd,
				n.a, n.d);
		end
	endtask : check_mem
	always @(posedge core_clk) begin
		cycles++;
		if (rdPend) check_reg(cpuRdData);
		rdPend = (cpuSel === 1'b1) && (cpuWrite === 1'b0);
		if (memWrite === 1'b1 && memAck === 1'b1) check_mem(memAddr, memWrData);
		if (cycles == LIMIT) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic regw(input logic [5:0] a, input logic [15:0] d);
		@(negedge core_clk);
		cpuSel = 1'b1;
		cpuWrite = 1'b1;
		cpuAddr = a;
		cpuWrData = d;
		@(negedge core_clk);
		cpuSel = 1'b0;
		cpuWrData = ~d;
	endtask : regw
	task automatic regr(input logic [5:0] a, input logic [15:0] e);
		rdQ.push_back(e);
		@(negedge core_clk);
		cpuSel = 1'b1;
		cpuWrite = 1'b0;
		cpuAddr = a;
		@(negedge core_clk);
		cpuSel = 1'b0;
	endtask : regr
	task automatic note(input logic [15:0] a, d, m);
		memQ.push_back('{a, d, m});
	endtask : note
	task automatic dat(input logic [15:0] v);
		note(dAddr, v, 16'hffff);
		dAddr++;
	endtask : dat
	task automatic blk(input logic [15:0] info, c1, c2, dp, s1, s2);
		if (cnt == 0) begin
			blkAddr = BLK_BASE;
			cnt = INIT_CNT;
		end
		note(blkAddr, info, 16'hffff);
		note(blkAddr + 16'h1, c1, 16'hffff);
		note(blkAddr + 16'h2, c2, 16'hffff);
		note(blkAddr + 16'h3, dp, 16'hffff);
		note(blkAddr + 16'h4, s1, 16'hffff);
		note(blkAddr + 16'h5, s2, 16'hffff);
		note(blkAddr + 16'h6, 16'h0, 16'h0);
		note(blkAddr + 16'h7, 16'h0, 16'hffff);
		note(logPtr, blkAddr, 16'hffff);
		logPtr[4:0] = logPtr[4:0] + 5'h1;
		blkAddr = blkAddr + 16'h8;
		cnt--;
	endtask : blk
	task automatic wd(input logic [15:0] v, input logic s, input logic [1:0] e);
		i_bus_traffic_model.send(v, s, onA, e);
	endtask : wd
	task automatic open();
		@(negedge core_clk);
		busGap = 1'b0;
	endtask : open
	task automatic idle();
		int n;
		n = 0;
		@(negedge core_clk);
		busGap = 1'b1;
		while (memQ.size() != 0 && n < 600) begin
			@(negedge core_clk);
			n++;
		end
		if (memQ.size() != 0) begin
			mismatches++;
			$display("unexpected stall at %0t: %h vs %h", $time, 16'h0, memQ[0].a);
			memQ.delete();
		end
		repeat (30) @(negedge core_clk);
	endtask : idle
	function automatic logic [15:0] cmd(input logic [4:0] ad, input logic tx,
		input logic [4:0] wc);
		return {ad, tx, 5'h01, wc};
	endfunction : cmd
	task automatic rxMsg(input logic [4:0] ad, input int n,
		input logic [1:0] er, input logic keep, input logic [15:0] info);
		logic [15:0] c, v, dp;
		c = cmd(ad, 1'b0, n[4:0]);
		dp = dAddr;
		open();
		wd(c, 1'b1, 2'h0);
		repeat (n) begin
			v = 16'($random(seed));
			if (keep && er == 2'h0) dat(v);
			wd(v, 1'b0, er);
		end
		if (keep) blk(info, c, 16'h0, dp, {ad, 11'h0}, 16'h0);
		wd({ad, 11'h0}, 1'b1, 2'h0);
		idle();
	endtask : rxMsg
	task automatic rtrt(input logic [4:0] rx, input logic [4:0] tx,
		input logic keep, input logic [15:0] info);
		logic [15:0] c1, c2, v, dp;
		c1 = cmd(rx, 1'b0, 5'h01);
		c2 = cmd(tx, 1'b1, 5'h01);
		v = 16'($random(seed));
		dp = dAddr;
		open();
		wd(c1, 1'b1, 2'h0);
		wd(c2, 1'b1, 2'h0);
		wd({tx, 11'h0}, 1'b1, 2'h0);
		if (keep) dat(v);
		if (keep) blk(info, c1, c2, dp, {tx, 11'h0}, {rx, 11'h0});
		wd(v, 1'b0, 2'h0);
		wd({rx, 11'h0}, 1'b1, 2'h0);
		idle();
	endtask : rtrt

	initial begin
		logic [15:0] c, v, dp;
		repeat (20) @(negedge core_clk);
		sys_rst = 1'b0;
		foreach (regs[i]) regr(regs[i], RESET_WORD);
		regw(REG_EXTRA, 16'hffff);
		regr(REG_EXTRA, {14'h0, EXTRA_MASK});
		regw(REG_TIMESTAMP, 16'h1234);
		regr(REG_TIMESTAMP, 16'h1234);
		regw(REG_BLKPTR, BLK_BASE);
		regw(REG_DATAPTR, DATA_BASE);
		regw(REG_BLKCNT, 16'(INIT_CNT));
		regw(REG_FILTLOW, 16'h0020);
		regw(REG_FILTHIGH, 16'h0002);
		regw(REG_LOGPTR, LOG_BASE);
		regr(REG_BLKPTR, BLK_BASE);
		rxMsg(5'h05, 1, 2'h0, 1'b0, 16'h0);
		rolePins = 2'h2;
		repeat (3) @(negedge core_clk);
		rxMsg(5'h05, 2, 2'h0, 1'b1, 16'h4200);
		regr(REG_LASTCMD, cmd(5'h05, 1'b0, 5'h02));
		onA = 1'b0;
		c = cmd(5'h11, 1'b1, 5'h01);
		v = 16'($random(seed));
		dp = dAddr;
		open();
		wd(c, 1'b1, 2'h0);
		wd(16'h8800, 1'b1, 2'h0);
		dat(v);
		blk(16'h4000, c, 16'h0, dp, 16'h8800, 16'h0);
		wd(v, 1'b0, 2'h0);
		idle();
		regr(REG_BLKCNT, 16'h0000);
		onA = 1'b1;
		rxMsg(5'h05, 1, 2'h1, 1'b1, 16'h4282);
		regr(REG_LOGPTR, logPtr);
		rxMsg(5'h06, 1, 2'h0, 1'b0, 16'h0);
		rtrt(5'h05, 5'h09, 1'b1, 16'h4300);
		regw(REG_OPSTATE, 16'h0300);
		rolePins = 2'h0;
		ownAddress = 5'h05;
		rxMsg(5'h05, 1, 2'h0, 1'b0, 16'h0);
		rtrt(5'h11, 5'h05, 1'b0, 16'h0);
		open();
		wd(cmd(5'h11, 1'b0, 5'h01), 1'b1, 2'h0);
		rtActive = 1'b1;
		wd(16'h5a5a, 1'b0, 2'h2);
		wd(16'h8800, 1'b1, 2'h0);
		rtActive = 1'b0;
		idle();
		rxMsg(5'h11, 3, 2'h0, 1'b1, 16'h4200);
		regr(REG_BLKCNT, 16'(cnt));
		give_verdict();
	end
endmodule : bus_monitor_store_bench
